//--- rtl/cmd_decoder.sv
module cmd_decoder
    import cmd_pkg::*;
#(
    parameter int TIMEOUT_CYC = SCAN_TIMEOUT_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    cmd_link_if.drive LINK,
    input wire logic NET_ENABLE,
    input wire logic NETSEL_ASSIGNED,
    input wire logic NETWORK_SELECT_INPUT,
    input wire logic MULTISPEED_SELECT_0,
    input wire logic MULTISPEED_SELECT_1,
    input wire logic MULTISPEED_SELECT_2,
    input wire logic MULTISPEED_SELECT_3,
    input wire logic JOG_INPUT,
    input wire logic SECOND_RAMP_SELECT,
    input wire logic LOCAL_FWD,
    input wire logic LOCAL_REV,
    input wire logic [15:0] LOCAL_FREQ,
    input wire logic [15:0] LOCAL_ACC,
    input wire logic [15:0] LOCAL_DEC,
    output logic RUN_FWD,
    output logic RUN_REV,
    output logic FAULT_RESET,
    output logic COAST_STOP,
    output logic LOCAL_OVERRIDE,
    output logic [15:0] FREQ_CMD,
    output logic [15:0] ACC_CMD,
    output logic [15:0] DEC_CMD,
    output logic RUN_KEY_LED
);
    // a timeout below two cycles would drop the link between back-to-back scans
    if (TIMEOUT_CYC < 2) begin : g_tmo_bad
        $error("TIMEOUT_CYC too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the local inputs
    logic [8:0] pin_s1_reg, pin_s2_reg;
    logic [8:0] pins;
    assign pins = {NETWORK_SELECT_INPUT, MULTISPEED_SELECT_0, MULTISPEED_SELECT_1, MULTISPEED_SELECT_2,
                   MULTISPEED_SELECT_3, JOG_INPUT, SECOND_RAMP_SELECT, LOCAL_FWD, LOCAL_REV};
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic netsel_s, local_prio, loc_fwd, loc_rev;
    assign netsel_s = pin_s2_reg[8];
    assign local_prio = |pin_s2_reg[7:2];
    assign loc_fwd = pin_s2_reg[1];
    assign loc_rev = pin_s2_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // record fields
    logic rec_ok;
    logic [7:0] ctl;
    logic [15:0] w_freq, w_acc, w_dec;
    assign rec_ok = LINK.rec_valid && LINK.layout == LAYOUT_SEL;
    assign ctl = LINK.rec_data[7:0];
    assign w_freq = LINK.rec_data[BYTE_FREQ*8 +: 16];
    assign w_acc = LINK.rec_data[BYTE_ACC*8 +: 16];
    assign w_dec = LINK.rec_data[BYTE_DEC*8 +: 16];

    logic net_enabled;
    assign net_enabled = NETSEL_ASSIGNED ? netsel_s : NET_ENABLE;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic netctl_reg, netctl_next, netref_reg, netref_next;
    logic fwd_reg, fwd_next, rev_reg, rev_next;
    logic fwd_armed_reg, fwd_armed_next, rev_armed_reg, rev_armed_next;
    logic frst_reg, frst_next, coast_reg, coast_next;
    logic [15:0] freq_reg, freq_next, acc_reg, acc_next, dec_reg, dec_next;
    logic acc_set_reg, acc_set_next, dec_set_reg, dec_set_next;
    logic [31:0] tmo_reg, tmo_next;
    logic online_reg, online_next;

    // next-state logic for the command record
    always_comb begin
        logic running;
        logic bf, br;
        running = RUN_FWD || RUN_REV;
        bf = ctl[BIT_FWD];
        br = ctl[BIT_REV];
        netctl_next = netctl_reg;
        netref_next = netref_reg;
        fwd_next = fwd_reg;
        rev_next = rev_reg;
        fwd_armed_next = fwd_armed_reg;
        rev_armed_next = rev_armed_reg;
        frst_next = 1'b0;
        coast_next = 1'b0;
        freq_next = freq_reg;
        acc_next = acc_reg;
        dec_next = dec_reg;
        acc_set_next = acc_set_reg;
        dec_set_next = dec_set_reg;
        online_next = online_reg;
        tmo_next = tmo_reg;
        if (rec_ok) begin
            tmo_next = '0;
            online_next = 1'b1;
            frst_next = ctl[BIT_FRESET];
            coast_next = ctl[BIT_COAST];
            if (!running) begin
                netctl_next = ctl[BIT_NETCTL];
                netref_next = ctl[BIT_NETREF];
            end
            // a run bit seen high before source was granted must fall first
            if (!bf || !netctl_next) fwd_armed_next = !bf;
            if (!br || !netctl_next) rev_armed_next = !br;
            fwd_next = bf && !br && (fwd_armed_reg || fwd_reg);
            rev_next = br && !bf && (rev_armed_reg || rev_reg);
            if (w_freq <= FREQ_MAX) freq_next = w_freq;
            if (w_acc >= RAMP_MIN && w_acc <= RAMP_MAX) begin
                acc_next = w_acc;
                acc_set_next = 1'b1;
            end
            if (w_dec >= RAMP_MIN && w_dec <= RAMP_MAX) begin
                dec_next = w_dec;
                dec_set_next = 1'b1;
            end
        end else if (tmo_reg >= 32'(TIMEOUT_CYC - 1)) begin
            online_next = 1'b0;
        end else begin
            tmo_next = tmo_reg + 32'd1;
        end
        // disabled network: run and source bits ignored, so no stale run on re-enable
        if (!net_enabled) begin
            netctl_next = netctl_reg;
            netref_next = netref_reg;
            fwd_next = 1'b0;
            rev_next = 1'b0;
            fwd_armed_next = 1'b0;
            rev_armed_next = 1'b0;
        end
        if (!LINK.link_up || !online_next) begin
            netctl_next = 1'b0;
            netref_next = 1'b0;
            fwd_next = 1'b0;
            rev_next = 1'b0;
            fwd_armed_next = 1'b0;
            rev_armed_next = 1'b0;
            online_next = online_next && LINK.link_up;
        end
    end

    // state registers; reset clears link and record, forcing reconnect
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            netctl_reg <= 1'b0;
            netref_reg <= 1'b0;
            fwd_reg <= 1'b0;
            rev_reg <= 1'b0;
            fwd_armed_reg <= 1'b0;
            rev_armed_reg <= 1'b0;
            frst_reg <= 1'b0;
            coast_reg <= 1'b0;
            freq_reg <= FREQ_RESET;
            acc_reg <= RAMP_RESET;
            dec_reg <= RAMP_RESET;
            acc_set_reg <= 1'b0;
            dec_set_reg <= 1'b0;
            tmo_reg <= '0;
            online_reg <= 1'b0;
        end else begin
            netctl_reg <= netctl_next;
            netref_reg <= netref_next;
            fwd_reg <= fwd_next;
            rev_reg <= rev_next;
            fwd_armed_reg <= fwd_armed_next;
            rev_armed_reg <= rev_armed_next;
            frst_reg <= frst_next;
            coast_reg <= coast_next;
            freq_reg <= freq_next;
            acc_reg <= acc_next;
            dec_reg <= dec_next;
            acc_set_reg <= acc_set_next;
            dec_set_reg <= dec_set_next;
            tmo_reg <= tmo_next;
            online_reg <= online_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output selection, registered
    logic net_run, net_prof;
    assign net_run = net_enabled && netctl_reg && !local_prio;
    assign net_prof = net_enabled && netref_reg && !local_prio;
    logic [4:0] ob_reg, ob_next;
    logic [47:0] prof_reg, prof_next;
    always_comb begin
        ob_next[0] = net_run ? fwd_reg : (loc_fwd && !loc_rev);
        ob_next[1] = net_run ? rev_reg : (loc_rev && !loc_fwd);
        ob_next[2] = frst_reg && net_enabled;
        ob_next[3] = coast_reg && net_enabled;
        ob_next[4] = !net_run;
        prof_next[15:0] = net_prof ? freq_reg : LOCAL_FREQ;
        prof_next[31:16] = (net_prof && acc_set_reg) ? acc_reg : LOCAL_ACC;
        prof_next[47:32] = (net_prof && dec_set_reg) ? dec_reg : LOCAL_DEC;
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ob_reg <= 5'h10;
            prof_reg <= '0;
        end else begin
            ob_reg <= ob_next;
            prof_reg <= prof_next;
        end
    end
    assign RUN_FWD = ob_reg[0];
    assign RUN_REV = ob_reg[1];
    assign FAULT_RESET = ob_reg[2];
    assign COAST_STOP = ob_reg[3];
    assign RUN_KEY_LED = ob_reg[4];
    assign LOCAL_OVERRIDE = local_prio;
    assign FREQ_CMD = prof_reg[15:0];
    assign ACC_CMD = prof_reg[31:16];
    assign DEC_CMD = prof_reg[47:32];
    assign LINK.online = online_reg; // monitor data keeps flowing even when disabled
endmodule

//--- rtl/cmd_pkg.sv
// Behaviour
// - layout 100 gives eight-byte record, control byte first
// - bit 0 forward run, clear means stop
// - bit 1 reverse run, clear means stop
// - bit 2 resets device, clears trip
// - bit 3 coasts motor to stop
// - bit 5 selects network run/stop source
// - bit 6 selects network frequency and ramps
// - bytes 2-7 hold three words, low first
// - frequency word in 0.01 Hz units
// - ramp words in 0.1 second units
// - out-of-range values dropped, old value kept
// - source bits frozen while running
// - local speed, jog, ramp inputs win
// - reset at power-up forces master reconnect
// - no ramps supplied means local ramps used
// - run-key indicator off under network control
// - network disabled ignores run and source bits
// - source clear or link loss reverts local
// - run bit before source bit is ignored
package cmd_pkg;
    localparam logic [7:0] LAYOUT_SEL = 8'h64;
    localparam int REC_BYTES = 8;
    localparam int BIT_FWD = 0;
    localparam int BIT_REV = 1;
    localparam int BIT_FRESET = 2;
    localparam int BIT_COAST = 3;
    localparam int BIT_NETCTL = 5;
    localparam int BIT_NETREF = 6;
    localparam int BYTE_FREQ = 2;
    localparam int BYTE_ACC = 4;
    localparam int BYTE_DEC = 6;
    // frequency in 0.01 Hz, ramps in 0.1 s
    localparam logic [15:0] FREQ_MAX = 16'h8CA0;
    localparam logic [15:0] RAMP_MIN = 16'h0001;
    localparam logic [15:0] RAMP_MAX = 16'h7530;
    localparam logic [15:0] FREQ_RESET = 16'h0000;
    localparam logic [15:0] RAMP_RESET = 16'h0000;
    localparam int SCAN_TIMEOUT_MS = 100;
    localparam int CLK_KHZ = 10000;
    localparam int SCAN_TIMEOUT_CYC = SCAN_TIMEOUT_MS * CLK_KHZ;
endpackage

//--- rtl/cmd_link_if.sv
interface cmd_link_if;
    logic rec_valid;
    logic [7:0] layout;
    logic [63:0] rec_data;
    logic link_up;
    logic online;
    modport master (output rec_valid, output layout, output rec_data, output link_up, input online);
    modport drive (input rec_valid, input layout, input rec_data, input link_up, output online);
endinterface

//--- rtl/cmd_master.sv
module cmd_master
    import cmd_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    cmd_link_if.master LINK,
    input wire logic SEND,
    input wire logic CONNECT,
    input wire logic NET_CONTROL,
    input wire logic NET_REFERENCE,
    input wire logic FWD,
    input wire logic REV,
    input wire logic FAULT_RST,
    input wire logic COAST,
    input wire logic [15:0] FREQ,
    input wire logic [15:0] ACC,
    input wire logic [15:0] DEC,
    output logic TIMEOUT
);
    // record is latched on SEND and offered for one cycle
    logic vld_reg, vld_next, up_reg, up_next, was_on_reg, was_on_next, tmo_reg, tmo_next;
    logic [63:0] data_reg, data_next;
    logic ctl_seen_reg, ctl_seen_next;
    always_comb begin
        logic runok;
        vld_next = 1'b0;
        data_next = data_reg;
        up_next = up_reg | CONNECT;
        was_on_next = was_on_reg;
        tmo_next = tmo_reg;
        ctl_seen_next = ctl_seen_reg;
        if (up_reg && was_on_reg && !LINK.online) begin
            tmo_next = 1'b1;
            up_next = CONNECT;
            was_on_next = 1'b0;
            ctl_seen_next = 1'b0;
        end else begin
            if (LINK.online) was_on_next = 1'b1;
            if (CONNECT) tmo_next = 1'b0;
        end
        // run bits only after control bit was already sent
        runok = ctl_seen_reg && NET_CONTROL;
        if (SEND && up_reg) begin
            vld_next = 1'b1;
            data_next = {DEC, ACC, FREQ, 8'h00,
                         1'b0, NET_REFERENCE, NET_CONTROL, 1'b0, COAST, FAULT_RST,
                         REV && runok, FWD && runok};
            ctl_seen_next = NET_CONTROL;
        end
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            vld_reg <= 1'b0;
            data_reg <= '0;
            up_reg <= 1'b0;
            was_on_reg <= 1'b0;
            tmo_reg <= 1'b0;
            ctl_seen_reg <= 1'b0;
        end else begin
            vld_reg <= vld_next;
            data_reg <= data_next;
            up_reg <= up_next;
            was_on_reg <= was_on_next;
            tmo_reg <= tmo_next;
            ctl_seen_reg <= ctl_seen_next;
        end
    end
    assign LINK.rec_valid = vld_reg;
    assign LINK.rec_data = data_reg;
    assign LINK.layout = LAYOUT_SEL;
    assign LINK.link_up = up_reg;
    assign TIMEOUT = tmo_reg;
endmodule

//--- verification/cmd_link_chk.sv
module cmd_link_chk
    import cmd_pkg::*;
#(
    parameter int TIMEOUT_CYC = 20
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic rec_valid,
    input wire logic [7:0] layout,
    input wire logic [63:0] rec_data,
    input wire logic link_up,
    input wire logic online
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] idle_reg;
    logic [15:0] idle_next;
    // cycles since last scan; saturates so a long silence never wraps to zero
    always_comb begin
        idle_next = rec_valid ? 16'h0000 : idle_reg + 16'((idle_reg != 16'hFFFF) ? 1 : 0);
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            idle_reg <= 16'h0000;
        end else begin
            idle_reg <= idle_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // layout and record framing
    a_layout_fixed: assert property (layout == LAYOUT_SEL)
        else $error("layout select left its fixed value");
    a_data_with_strobe: assert property ($changed(rec_data) |-> rec_valid)
        else $error("record changed without a strobe");
    a_run_needs_ctl: assert property (rec_valid && (rec_data[BIT_FWD] || rec_data[BIT_REV]) |-> rec_data[BIT_NETCTL])
        else $error("run bit sent without network control bit");
    a_strobe_after_link: assert property (rec_valid |-> $past(link_up))
        else $error("record sent before link was up");
    a_quiet_offline: assert property (!link_up |-> !rec_valid)
        else $error("record sent while link down");
    // drive presence follows scans
    a_online_after_rec: assert property (rec_valid |=> online)
        else $error("drive not online after a record");
    a_online_cause: assert property ($rose(online) |-> $past(rec_valid))
        else $error("drive online without a scan");
    a_scan_loss_off: assert property (idle_reg >= TIMEOUT_CYC + 4 |-> !online)
        else $error("drive still online after scan loss");
endmodule

//--- verification/tb_polled_command_decoder.sv
module tb_polled_command_decoder;
    import cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rstn = 1'b0, net_en = 1'b1, nsel_as = 1'b0, nsel = 1'b0, lfwd = 1'b0, lrev = 1'b0;
    logic send = 1'b0, conn = 1'b0;
    logic [5:0] pins = 6'h00;
    logic [7:0] ctl = 8'h00;
    logic [15:0] lf = 16'h05DC, la = 16'h0032, ld = 16'h0028, f = 16'h0000, a = 16'h0000, d = 16'h0000;
    logic rf, rr, frs, cst, lov, led, tmo;
    logic [15:0] fc, ac, dc;
    int fail_count = 0, cmp_count = 0;
    // status bits: run fwd, run rev, fault reset, coast, run-key led
    wire [15:0] st = {11'h000, rf, rr, frs, cst, led};
    cmd_link_if cmd_link_if_i ();
    cmd_decoder #(.TIMEOUT_CYC(100)) cmd_decoder_i (.CLK(clk), .RESETN(rstn), .LINK(cmd_link_if_i.drive),
        .NET_ENABLE(net_en), .NETSEL_ASSIGNED(nsel_as), .NETWORK_SELECT_INPUT(nsel),
        .MULTISPEED_SELECT_0(pins[0]), .MULTISPEED_SELECT_1(pins[1]), .MULTISPEED_SELECT_2(pins[2]),
        .MULTISPEED_SELECT_3(pins[3]), .JOG_INPUT(pins[4]), .SECOND_RAMP_SELECT(pins[5]),
        .LOCAL_FWD(lfwd), .LOCAL_REV(lrev), .LOCAL_FREQ(lf), .LOCAL_ACC(la), .LOCAL_DEC(ld),
        .RUN_FWD(rf), .RUN_REV(rr), .FAULT_RESET(frs), .COAST_STOP(cst), .LOCAL_OVERRIDE(lov),
        .FREQ_CMD(fc), .ACC_CMD(ac), .DEC_CMD(dc), .RUN_KEY_LED(led));
    cmd_master cmd_master_i (.CLK(clk), .RESETN(rstn), .LINK(cmd_link_if_i.master), .SEND(send), .CONNECT(conn),
        .NET_CONTROL(ctl[5]), .NET_REFERENCE(ctl[6]), .FWD(ctl[0]), .REV(ctl[1]), .FAULT_RST(ctl[2]),
        .COAST(ctl[3]), .FREQ(f), .ACC(a), .DEC(d), .TIMEOUT(tmo));
    cmd_link_chk #(.TIMEOUT_CYC(100)) cmd_link_chk_i (.CLK(clk), .RESETN(rstn),
        .rec_valid(cmd_link_if_i.rec_valid), .layout(cmd_link_if_i.layout), .rec_data(cmd_link_if_i.rec_data),
        .link_up(cmd_link_if_i.link_up), .online(cmd_link_if_i.online));
    ////////////////////////////////////////////////////////////////////////
    // free-running 10 MHz clock
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // one record; ends on the negedge where decoder outputs and pulses show
    task automatic tx(input logic [7:0] c, input logic [15:0] ff, input logic [15:0] aa, input logic [15:0] dd);
        ctl = c;
        f = ff;
        a = aa;
        d = dd;
        send = 1'b1;
        @(negedge clk) send = 1'b0;
        // pulses stand one cycle only, so look right after the outputs update
        repeat (2) @(negedge clk);
    endtask
    // connect pulse, then a bounded wait for the link
    task automatic link();
        conn = 1'b1;
        @(negedge clk) conn = 1'b0;
        for (int i = 0; i < 50 && cmd_link_if_i.link_up !== 1'b1; i++) @(negedge clk);
        if (cmd_link_if_i.link_up !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence; in-range words are stored from every record, used only while the decoder's reference bit is set
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        chk("led", 16'h0001, st);
        link();
        tx(8'h20, 16'h0000, 16'h0000, 16'h0000);
        chk("st", 16'h0000, st);
        tx(8'h60, 16'h07D0, 16'h0000, 16'h0000);
        chk("freq", 16'h07D0, fc);
        chk("acc", la, ac);
        chk("dec", ld, dc);
        tx(8'h21, 16'h0000, 16'h0000, 16'h0000);
        chk("st", 16'h0010, st);
        chk("acc", la, ac);
        tx(8'h61, 16'h07D0, 16'h0064, 16'h0064);
        chk("freq", lf, fc);
        tx(8'h20, 16'h07D0, 16'h0064, 16'h0064);
        chk("st", 16'h0000, st);
        tx(8'h60, 16'h07D0, 16'h0064, 16'h0064);
        chk("freq", 16'h07D0, fc);
        chk("acc", 16'h0064, ac);
        chk("dec", 16'h0064, dc);
        tx(8'h62, 16'h07D0, 16'h0064, 16'h0064);
        chk("st", 16'h0008, st);
        tx(8'h63, 16'h07D0, 16'h0064, 16'h0064);
        chk("st", 16'h0000, st);
        tx(8'h60, 16'h8CA1, 16'h0000, 16'h7531);
        chk("freq", 16'h07D0, fc);
        chk("acc", 16'h0064, ac);
        tx(8'h60, 16'h8CA0, 16'h0001, 16'h7530);
        chk("freq", 16'h8CA0, fc);
        chk("dec", 16'h7530, dc);
        tx(8'hF4, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0004, st);
        tx(8'h68, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0002, st);
        // each local priority pin in turn
        for (int i = 0; i < 6; i++) begin
            pins = 6'h01 << i;
            repeat (4) @(negedge clk);
            chk("ovr", 16'h0001, 16'(lov));
            chk("st", 16'h0001, st);
            pins = 6'h00;
            repeat (4) @(negedge clk);
            chk("ovr", 16'h0000, 16'(lov));
        end
        net_en = 1'b0;
        repeat (4) @(negedge clk);
        tx(8'h21, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0001, st);
        lfwd = 1'b1;
        repeat (4) @(negedge clk);
        chk("st", 16'h0011, st);
        lfwd = 1'b0;
        nsel_as = 1'b1;
        nsel = 1'b1;
        repeat (4) @(negedge clk);
        chk("st", 16'h0000, st);
        tx(8'h60, 16'h8CA0, 16'h0001, 16'h7530);
        tx(8'h61, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0010, st);
        tx(8'h00, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0000, st);
        tx(8'h00, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0001, st);
        tx(8'h20, 16'h8CA0, 16'h0001, 16'h7530);
        repeat (150) @(negedge clk);
        chk("st", 16'h0001, st);
        chk("tmo", 16'h0001, 16'(tmo));
        link();
        tx(8'h20, 16'h8CA0, 16'h0001, 16'h7530);
        tx(8'h21, 16'h8CA0, 16'h0001, 16'h7530);
        chk("st", 16'h0010, st);
        finish_test();
    end
endmodule
